/* File: inc/bcfg_cfg.svh */
// constants of the low-voltage buck configuration block: offsets, fields, resets, timing
// assumes a 250 MHz control clock and a 32-bit AHB-Lite register bus
//
// Overview of operation
// - one 5-bit code sets run and standby voltage
// - code change while on: discharge, then re-enable
// - power up loads code from stored default
// - code maps to set-point table, 27..31 4.10V
// - run mode defaults autoskip in sequence, else off
// - standby mode defaults autoskip in sequence, else off
// - mode 00 off, 01 pwm, 10 pfm, 11 autoskip
// - mode change sets event; unmasked asserts interrupt low
// - run to standby keeps voltage unless enable changes
// - current limit select picks 2.1/2.6/3.0/4.5 A
// - phase select resets to zero degrees, host writable
// - phase 000..110 is 45..315 degrees, 111 zero
// - stored inductor select drives power stage, 11 reserved
`ifndef BCFG_CFG_SVH
`define BCFG_CFG_SVH

// ========================================
// register byte offsets
`define BCFG_CTRL_OFS 8'h00
`define BCFG_STAT_OFS 8'h04
`define BCFG_ISTAT_OFS 8'h08
`define BCFG_IEN_OFS 8'h0c
`define BCFG_ICLR_OFS 8'h10

// ========================================
// field positions
`define BCFG_VC_LSB 0
`define BCFG_RUNM_LSB 8
`define BCFG_STBM_LSB 10
`define BCFG_ILIM_LSB 12
`define BCFG_PH_LSB 16
`define BCFG_ST_MODE_LSB 8
`define BCFG_ST_STBY_BIT 12
`define BCFG_ST_DISCH_BIT 13
`define BCFG_ST_EN_BIT 14
`define BCFG_ST_IND_LSB 16
`define BCFG_INT_MODE_BIT 0

// ========================================
// reset and default values
`define BCFG_VC_RST 5'h00
`define BCFG_VC_MAX 5'h1b
`define BCFG_MODE_OFF 2'h0
`define BCFG_MODE_PWM 2'h1
`define BCFG_MODE_PFM 2'h2
`define BCFG_MODE_AUTO 2'h3
`define BCFG_ILIM_RST 2'h0
`define BCFG_PHASE_RST 3'h7
`define BCFG_BOOT_LOAD 2'h2

// ========================================
// timing
`define BCFG_CLK_PERIOD_PS 4000
`define BCFG_DISCH_TIME_NS 2000
`define BCFG_DISCH_CYC ((`BCFG_DISCH_TIME_NS * 1000 + `BCFG_CLK_PERIOD_PS - 1) / `BCFG_CLK_PERIOD_PS)

`endif

/* File: inc/bcfg_pkg.sv */
// types of the low-voltage buck configuration block
// assumes nothing beyond the constants header
package bcfg_pkg;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_RUN = 3'b010,
		S_DISCH = 3'b100
	} bcfg_state_t;

	typedef struct packed {
		logic [2:0] phase;
		logic [1:0] ilim;
		logic [1:0] stby_mode;
		logic [1:0] run_mode;
		logic [4:0] vcode;
	} bcfg_ctrl_t;

	typedef struct packed {
		logic enable;
		logic discharge;
		logic pwm;
		logic pfm;
		logic autoskip;
		logic [4:0] code;
		logic [1:0] ilim;
		logic [2:0] phase;
		logic [1:0] inductor;
	} bcfg_stage_t;

endpackage

/* File: core/bcfg_top.sv */
// configuration and sequencing logic of the low-voltage buck regulator
// assumes an AHB-Lite master on mclk; straps and standby request are asynchronous pins
`timescale 1ns/1ps
`include "bcfg_cfg.svh"

module bcfg_top
	import bcfg_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic powerup_seq_member,
	input wire logic [4:0] stored_voltage_default,
	input wire logic [1:0] inductor_select_otp,
	input wire logic standby_req,
	output bcfg_stage_t stage,
	output logic [12:0] setpoint_mv,
	output logic [12:0] current_limit_ma,
	output logic [8:0] phase_deg,
	output logic [10:0] inductor_nh,
	output logic inductor_reserved,
	output logic interrupt_out_n
);

	// ========================================
	// pin synchronisers
	logic [8:0] sync1;
	logic [8:0] sync2;
	logic [1:0] boot;
	logic load;
	logic stby_s;
	logic seq_s;
	logic [4:0] otp_code_s;
	logic [1:0] otp_ind_s;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
		end else begin
			sync1 <= {standby_req, powerup_seq_member, stored_voltage_default, inductor_select_otp};
			sync2 <= sync1;
		end
	end

	assign stby_s = sync2[8];
	assign seq_s = sync2[7];
	assign otp_code_s = sync2[6:2];
	assign otp_ind_s = sync2[1:0];

	// defaults are taken once the synchronisers hold the straps
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			boot <= 2'h0;
		end else if (boot != 2'h3) begin
			boot <= boot + 2'h1;
		end
	end

	assign load = (boot == `BCFG_BOOT_LOAD);

	// ========================================
	// AHB-Lite slave
	logic wr_pend;
	logic rd_pend;
	logic [7:0] addr_q;
	logic accept;
	logic wr_ctrl;
	logic wr_ien;
	logic wr_iclr;

	assign accept = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend <= accept & hwrite;
			rd_pend <= accept & ~hwrite;
			if (accept) begin
				addr_q <= {haddr[7:2], 2'h0};
			end
		end
	end

	assign wr_ctrl = wr_pend & (addr_q == `BCFG_CTRL_OFS);
	assign wr_ien = wr_pend & (addr_q == `BCFG_IEN_OFS);
	assign wr_iclr = wr_pend & (addr_q == `BCFG_ICLR_OFS);

	// ========================================
	// configuration register
	bcfg_ctrl_t ctrl;
	bcfg_ctrl_t next_ctrl;
	logic [1:0] inductor;
	logic [1:0] dflt_mode;

	assign dflt_mode = seq_s ? `BCFG_MODE_AUTO : `BCFG_MODE_OFF;
	assign next_ctrl = '{phase: hwdata[`BCFG_PH_LSB +: 3], ilim: hwdata[`BCFG_ILIM_LSB +: 2],
		stby_mode: hwdata[`BCFG_STBM_LSB +: 2], run_mode: hwdata[`BCFG_RUNM_LSB +: 2],
		vcode: hwdata[`BCFG_VC_LSB +: 5]};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= '{phase: `BCFG_PHASE_RST, ilim: `BCFG_ILIM_RST, stby_mode: `BCFG_MODE_OFF,
				run_mode: `BCFG_MODE_OFF, vcode: `BCFG_VC_RST};
			inductor <= 2'h0;
		end else if (load) begin
			ctrl.vcode <= otp_code_s;
			ctrl.run_mode <= dflt_mode;
			ctrl.stby_mode <= dflt_mode;
			inductor <= otp_ind_s;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl;
		end
	end

	// ========================================
	// mode selection and discharge sequencer
	bcfg_state_t st;
	logic [9:0] dcnt;
	logic [4:0] applied;
	logic [1:0] sel_mode;
	logic [1:0] mode_q;
	logic want_on;
	logic code_diff;
	logic disch_end;
	logic mode_evt;

	// one mode field per state; the code is common to both
	assign sel_mode = stby_s ? ctrl.stby_mode : ctrl.run_mode;
	assign want_on = (sel_mode != `BCFG_MODE_OFF);
	assign code_diff = (ctrl.vcode != applied);
	assign disch_end = (dcnt == 10'(`BCFG_DISCH_CYC - 1));

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= S_IDLE;
			dcnt <= 10'h000;
			applied <= `BCFG_VC_RST;
		end else begin
			case (st)
				S_IDLE: begin
					applied <= ctrl.vcode;
					if (want_on) begin
						st <= S_RUN;
					end
				end
				S_RUN: begin
					dcnt <= 10'h000;
					if (!want_on) begin
						st <= S_IDLE;
					end else if (code_diff) begin
						st <= S_DISCH;
					end
				end
				S_DISCH: begin
					dcnt <= dcnt + 10'h001;
					if (disch_end) begin
						applied <= ctrl.vcode;
						st <= S_RUN;
					end
				end
				default: begin
					st <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= `BCFG_MODE_OFF;
		end else begin
			mode_q <= sel_mode;
		end
	end

	assign mode_evt = (sel_mode != mode_q);

	// ========================================
	// power stage controls
	logic run_en;

	assign run_en = (st == S_RUN);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stage <= '0;
		end else begin
			stage.enable <= run_en & want_on;
			stage.discharge <= (st == S_DISCH);
			stage.pwm <= run_en & (sel_mode == `BCFG_MODE_PWM);
			stage.pfm <= run_en & (sel_mode == `BCFG_MODE_PFM);
			stage.autoskip <= run_en & (sel_mode == `BCFG_MODE_AUTO);
			stage.code <= applied;
			stage.ilim <= ctrl.ilim;
			stage.phase <= ctrl.phase;
			stage.inductor <= inductor;
		end
	end

	// ========================================
	// decoded figures for the analog trims
	localparam logic [12:0] VTAB [0:27] = '{
		13'h3e8, 13'h44c, 13'h4b0, 13'h4e2, 13'h514, 13'h546, 13'h5dc, 13'h640,
		13'h708, 13'h73a, 13'h7d0, 13'h834, 13'h866, 13'h8ca, 13'h8fc, 13'h960,
		13'h9c4, 13'haf0, 13'hc4e, 13'hc80, 13'hcb2, 13'hce4, 13'hd16, 13'hd48,
		13'hdac, 13'hed8, 13'hfa0, 13'h1004};
	localparam logic [12:0] ITAB [0:3] = '{13'h834, 13'ha28, 13'hbb8, 13'h1194};
	localparam logic [10:0] LTAB [0:3] = '{11'h3e8, 11'h1d6, 11'h5dc, 11'h000};

	logic [4:0] vidx;
	logic [8:0] next_phase_deg;

	assign vidx = (stage.code > `BCFG_VC_MAX) ? `BCFG_VC_MAX : stage.code;
	assign next_phase_deg = (ctrl.phase == 3'h7) ? 9'h000 : 9'({ctrl.phase, 3'h0} + {3'h0, ctrl.phase}) * 9'h005
		+ 9'h02d;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			setpoint_mv <= 13'h000;
			current_limit_ma <= 13'h000;
			phase_deg <= 9'h000;
			inductor_nh <= 11'h000;
			inductor_reserved <= 1'b0;
		end else begin
			setpoint_mv <= VTAB[vidx];
			current_limit_ma <= ITAB[ctrl.ilim];
			phase_deg <= next_phase_deg;
			inductor_nh <= LTAB[inductor];
			inductor_reserved <= (inductor == 2'h3);
		end
	end

	// ========================================
	// interrupt status, enable and clear
	logic [7:0] int_stat;
	logic [7:0] int_en;
	logic [7:0] clr_mask;

	assign clr_mask = wr_iclr ? hwdata[7:0] : 8'h00;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			int_stat <= 8'h00;
			int_en <= 8'h00;
		end else begin
			int_stat <= (int_stat & ~clr_mask) | {7'h00, mode_evt};
			if (wr_ien) begin
				int_en <= hwdata[7:0];
			end
		end
	end

	assign interrupt_out_n = ~|(int_stat & int_en);

	// ========================================
	// read mux
	logic [31:0] stat_word;
	logic [31:0] ctrl_word;

	assign ctrl_word = {13'h0000, ctrl.phase, 2'h0, ctrl.ilim, ctrl.stby_mode, ctrl.run_mode, 3'h0, ctrl.vcode};
	assign stat_word = {14'h0000, inductor, 1'b0, stage.enable, stage.discharge, stby_s, 2'h0, sel_mode,
		3'h0, applied};
	assign hrdata = !rd_pend ? 32'h00000000 :
		(addr_q == `BCFG_CTRL_OFS) ? ctrl_word :
		(addr_q == `BCFG_STAT_OFS) ? stat_word :
		(addr_q == `BCFG_ISTAT_OFS) ? {24'h000000, int_stat} :
		(addr_q == `BCFG_IEN_OFS) ? {24'h000000, int_en} : 32'h00000000;

	// ========================================
	// assertions
	vtab_top_a: assert property (@(posedge mclk) disable iff (!nrst)
		stage.code >= `BCFG_VC_MAX |=> setpoint_mv == 13'h1004)
		else $error("set point not 4.10 V at top codes");

	disch_first_a: assert property (@(posedge mclk) disable iff (!nrst)
		st == S_RUN && want_on && code_diff |=> st == S_DISCH ##1 stage.discharge && !stage.enable)
		else $error("code change did not start discharge");

	disch_apply_a: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(st == S_DISCH) |-> applied == $past(ctrl.vcode) && st == S_RUN)
		else $error("new code not applied after discharge");

	applied_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		st == S_RUN |=> $stable(applied))
		else $error("voltage changed while regulating");

	boot_load_a: assert property (@(posedge mclk) disable iff (!nrst)
		load |=> ctrl.vcode == $past(otp_code_s) && inductor == $past(otp_ind_s))
		else $error("stored defaults not loaded");

	mode_dflt_a: assert property (@(posedge mclk) disable iff (!nrst)
		load |=> ctrl.run_mode == ($past(seq_s) ? 2'h3 : 2'h0) && ctrl.stby_mode == ctrl.run_mode)
		else $error("mode defaults wrong");

	stby_dflt_a: assert property (@(posedge mclk) disable iff (!nrst)
		load && !seq_s |=> ctrl.stby_mode == 2'h0)
		else $error("standby default wrong");

	mode_dec_a: assert property (@(posedge mclk) disable iff (!nrst)
		st == S_RUN && sel_mode == 2'h2 |=> stage.pfm && !stage.pwm && !stage.autoskip)
		else $error("mode decode wrong");

	evt_set_a: assert property (@(posedge mclk) disable iff (!nrst)
		mode_evt |=> int_stat[0] ##0 (interrupt_out_n == !int_en[0]))
		else $error("mode change event lost");

	evt_sticky_a: assert property (@(posedge mclk) disable iff (!nrst)
		int_stat[0] && !(wr_iclr && hwdata[0]) |=> int_stat[0])
		else $error("event flag dropped without clear");

	stby_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
		st == S_RUN && want_on && !code_diff && $changed(stby_s) |=> st == S_RUN)
		else $error("standby toggle disturbed output");

	ilim_map_a: assert property (@(posedge mclk) disable iff (!nrst)
		ctrl.ilim == 2'h3 && $stable(ctrl.ilim) |=> current_limit_ma == 13'h1194)
		else $error("current limit decode wrong");

	phase_map_a: assert property (@(posedge mclk) disable iff (!nrst)
		ctrl.phase == 3'h3 |=> phase_deg == 9'h0b4)
		else $error("phase decode wrong");

	phase_rst_a: assert property (@(posedge mclk) disable iff (!nrst)
		load |-> ctrl.phase == 3'h7)
		else $error("phase not zero after power up");

	ind_res_a: assert property (@(posedge mclk) disable iff (!nrst)
		inductor == 2'h3 |=> inductor_reserved)
		else $error("reserved inductor not flagged");

	cov_disch_c: cover property (@(posedge mclk) disable iff (!nrst) $fell(st == S_DISCH));
	cov_irq_c: cover property (@(posedge mclk) disable iff (!nrst) $fell(interrupt_out_n));
	cov_stby_c: cover property (@(posedge mclk) disable iff (!nrst) st == S_RUN && $rose(stby_s));

endmodule

/* File: dv/bcfg_host.sv */
// host model: single-word ahb-lite master issuing register accesses
// assumes hready is the slave's hreadyout and a clock shared with the block
`timescale 1ns/1ps

module bcfg_host (
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// ========================================
	// bus idle state
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// ========================================
	// one transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		// released address lines must not keep their last value either
		haddr <= ~{24'h0, a};
		hwrite <= ~wr;
		hwdata <= wr ? d : ~hwdata;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
		// released data lines must not keep their last value
		hwdata <= ~d;
	endtask
endmodule

/* File: dv/tb_buck_regulator_config.sv */
// testbench of the buck configuration block with a table-driven reference model
// assumes the host model in bcfg_host.sv and the constants header
`timescale 1ns/1ps
`include "bcfg_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_buck_regulator_config
	import bcfg_pkg::*;
;
	logic mclk, nrst, hsel, hwrite, hreadyout, hresp, powerup_seq_member, standby_req;
	logic inductor_reserved, interrupt_out_n;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans, inductor_select_otp;
	logic [2:0] hsize;
	logic [4:0] stored_voltage_default, c1, c2;
	logic [12:0] setpoint_mv, current_limit_ma;
	logic [8:0] phase_deg;
	logic [10:0] inductor_nh;
	bcfg_stage_t stage;
	logic [31:0] lfsr = 32'hddb73cbd;
	int n_errors = 0;
	int n_checks = 0;
	int n;
	int mv_tab[32] = '{1000, 1100, 1200, 1250, 1300, 1350, 1500, 1600, 1800, 1850, 2000, 2100, 2150, 2250, 2300,
		2400, 2500, 2800, 3150, 3200, 3250, 3300, 3350, 3400, 3500, 3800, 4000, 4100, 4100, 4100, 4100, 4100};
	int ma_tab[4] = '{2100, 2600, 3000, 4500};
	int nh_tab[4] = '{1000, 470, 1500, 0};

	bcfg_top bcfg_top_i (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.powerup_seq_member(powerup_seq_member), .stored_voltage_default(stored_voltage_default),
		.inductor_select_otp(inductor_select_otp), .standby_req(standby_req), .stage(stage),
		.setpoint_mv(setpoint_mv), .current_limit_ma(current_limit_ma), .phase_deg(phase_deg),
		.inductor_nh(inductor_nh), .inductor_reserved(inductor_reserved), .interrupt_out_n(interrupt_out_n));

	bcfg_host bcfg_host_i (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ========================================
	// helpers
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] ctl(logic [2:0] ph, logic [1:0] il, logic [1:0] sb, logic [1:0] rn, logic [4:0] vc);
		return {13'h0, ph, 2'h0, il, sb, rn, 3'h0, vc};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bcfg_host_i.xfer(1'b1, a, d, unused);
		// the write lands on this edge: let it settle before outputs are sampled
		@(negedge mclk);
	endtask

	task automatic rd(input logic [7:0] a);
		bcfg_host_i.xfer(1'b0, a, 32'h0, q);
	endtask

	task automatic finish_test();
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ========================================
	// clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		finish_test();
	end

	// ========================================
	// main sequence
	initial begin
		nrst = 1'b0;
		standby_req = 1'b0;
		powerup_seq_member = 1'b1;
		lfsr = rnd(lfsr);
		stored_voltage_default = lfsr[4:0];
		inductor_select_otp = lfsr[9:8];
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(`BCFG_CTRL_OFS);
		`CHK(q, ctl(3'h7, 2'h0, 2'h3, 2'h3, stored_voltage_default))
		`CHK(stage.code, stored_voltage_default)
		`CHK(stage.autoskip, 1'b1)
		`CHK(inductor_nh, 11'(nh_tab[inductor_select_otp]))
		`CHK(inductor_reserved, inductor_select_otp == 2'h3)
		`CHK(stage.inductor, inductor_select_otp)
		rd(`BCFG_ISTAT_OFS);
		`CHK(q, 32'h1)
		`CHK(interrupt_out_n, 1'b1)
		wr(`BCFG_IEN_OFS, 32'h1);
		`CHK(interrupt_out_n, 1'b0)
		wr(`BCFG_IEN_OFS, 32'h0);
		rd(`BCFG_ISTAT_OFS);
		`CHK(q, 32'h1)
		`CHK(interrupt_out_n, 1'b1)
		wr(`BCFG_ICLR_OFS, 32'h1);
		rd(`BCFG_ISTAT_OFS);
		`CHK(q, 32'h0)
		wr(`BCFG_IEN_OFS, 32'h1);
		// regulator off: codes apply at once, so the whole table is swept quickly
		wr(`BCFG_CTRL_OFS, ctl(3'h7, 2'h0, 2'h0, 2'h0, stored_voltage_default));
		for (int c = 0; c < 32; c++) begin
			wr(`BCFG_CTRL_OFS, ctl(c[2:0], c[1:0], 2'h0, 2'h0, c[4:0]));
			repeat (5) @(posedge mclk);
			`CHK(setpoint_mv, 13'(mv_tab[c]))
			`CHK(current_limit_ma, 13'(ma_tab[c[1:0]]))
			`CHK(phase_deg, (c[2:0] == 3'h7) ? 9'h0 : 9'((c[2:0] + 1) * 45))
			`CHK({stage.ilim, stage.phase}, {c[1:0], c[2:0]})
		end
		for (int m = 1; m < 5; m++) begin
			wr(`BCFG_ICLR_OFS, 32'h1);
			wr(`BCFG_CTRL_OFS, ctl(3'h0, 2'h0, 2'h0, m[1:0], 5'h1f));
			repeat (5) @(posedge mclk);
			`CHK({stage.enable, stage.pwm, stage.pfm, stage.autoskip}, {m[1:0] != 2'h0, m[1:0] == 2'h1,
				m[1:0] == 2'h2, m[1:0] == 2'h3})
			`CHK(interrupt_out_n, 1'b0)
		end
		lfsr = rnd(lfsr);
		c1 = lfsr[4:0];
		c2 = ~c1;
		wr(`BCFG_CTRL_OFS, ctl(3'h0, 2'h0, 2'h2, 2'h0, c1));
		wr(`BCFG_CTRL_OFS, ctl(3'h0, 2'h0, 2'h2, 2'h1, c1));
		repeat (5) @(posedge mclk);
		wr(`BCFG_CTRL_OFS, ctl(3'h0, 2'h0, 2'h2, 2'h1, c2));
		n = 0;
		while (stage.discharge !== 1'b1 && n < 10) begin
			@(posedge mclk);
			n++;
		end
		`CHK({stage.discharge, stage.enable}, 2'b10)
		n = 0;
		while (stage.discharge === 1'b1 && n < 1000) begin
			@(posedge mclk);
			n++;
		end
		`CHK(n, `BCFG_DISCH_CYC)
		repeat (3) @(posedge mclk);
		`CHK({stage.enable, stage.code}, {1'b1, c2})
		`CHK(setpoint_mv, 13'(mv_tab[c2]))
		@(posedge mclk);
		standby_req <= 1'b1;
		n = 0;
		repeat (10) begin
			@(posedge mclk);
			n += int'(stage.discharge === 1'b1);
		end
		`CHK(n, 0)
		`CHK({stage.enable, stage.pfm, stage.code}, {2'b11, c2})
		rd(`BCFG_STAT_OFS);
		`CHK(q, {14'h0, inductor_select_otp, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 2'h2, 3'h0, c2})
		wr(`BCFG_CTRL_OFS, ctl(3'h0, 2'h0, 2'h0, 2'h1, c2));
		repeat (5) @(posedge mclk);
		`CHK(stage.enable, 1'b0)
		standby_req <= 1'b0;
		repeat (8) @(posedge mclk);
		`CHK({stage.enable, stage.pwm}, 2'b11)
		// second power up with the regulator left out of the sequence
		nrst <= 1'b0;
		powerup_seq_member <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(`BCFG_CTRL_OFS);
		`CHK(q, ctl(3'h7, 2'h0, 2'h0, 2'h0, stored_voltage_default))
		`CHK(stage.enable, 1'b0)
		rd(`BCFG_ISTAT_OFS);
		`CHK(q, 32'h0)
		finish_test();
	end
endmodule
